// ===== include/ddr_burst_sram_map.vh
// Constants shared by the burst SRAM read port, its FIFO and its pin synchroniser.
`ifndef DDR_BURST_SRAM_MAP_VH
`define DDR_BURST_SRAM_MAP_VH

`define ADDR_W 20
`define DATA_W 18
`define LANE_W 9
`define LANES 2
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define STRAP_SETTLE_CYC 3'h5

`endif

// ===== rtl/burst_fifo.v
// Small flip-flop FIFO holding fetched read bursts until the output side launches them.
`timescale 1ns/1ps
`default_nettype none
module burst_fifo #(
	parameter WIDTH = 36,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk_sys, // system clock
	input wire rst, // asynchronous reset, active high
	input wire in_valid, // write side offers a word
	output wire in_ready, // room for a word
	input wire [WIDTH-1:0] in_data, // word to store
	output wire out_valid, // a word is at the head
	input wire out_ready, // drain side takes the head
	output wire [WIDTH-1:0] out_data // head word
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = store[rd_ptr];

	always @(posedge clk_sys) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/ddr_burst_sram_read_port.v
// Burst SRAM core with two-word read path, sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "ddr_burst_sram_map.vh"
module ddr_burst_sram_read_port #(
	parameter ADDR_W = `ADDR_W,
	parameter DATA_W = `DATA_W,
	parameter FIFO_DEPTH = `FIFO_DEPTH,
	parameter FIFO_AW = `FIFO_AW
) (
	input wire clk_sys, // system clock, 100 MHz
	input wire rst, // asynchronous reset, active high
	input wire k, // positive input clock pin
	input wire k_n, // negative input clock pin
	input wire c, // positive output clock pin
	input wire c_n, // negative output clock pin
	input wire load_strobe_n, // command strobe, active low
	input wire rw_sel, // direction select, high for read
	input wire [ADDR_W-1:0] addr, // burst address
	input wire [1:0] lane_write_mask_n, // per-lane write enables, active low
	input wire delay_loop_off_n, // strap: low selects one-cycle latency
	input wire [DATA_W-1:0] dq_in, // data pins as seen from outside
	output reg [DATA_W-1:0] dq_out, // data driven onto the pins
	output reg dq_oe, // high while data pins are driven
	output reg dll_mode, // strap result: 1.5-cycle latency active
	output reg single_clk_mode, // strap result: input clocks time the outputs
	output reg read_overrun // sticky: a read burst was dropped
);
	localparam IN_W = DATA_W + 2 + ADDR_W + 7;
	localparam OST_IDLE = 3'b001;
	localparam OST_WORD0 = 3'b010;
	localparam OST_WORD1 = 3'b100;

	// Second word of a burst: the one-bit counter wraps, flipping the low bit.
	function [ADDR_W-1:0] burst_second;
		input [ADDR_W-1:0] a;
		reg step;
		begin
			step = a[0] + 1'b1;
			burst_second = {a[ADDR_W-1:1], step};
		end
	endfunction

	// Merge new data into stored data lane by lane, where the mask is low.
	function [DATA_W-1:0] lane_merge;
		input [DATA_W-1:0] old_w;
		input [DATA_W-1:0] new_w;
		input [1:0] mask_n;
		begin
			lane_merge = old_w;
			if (!mask_n[0]) begin
				lane_merge[`LANE_W-1:0] = new_w[`LANE_W-1:0];
			end
			if (!mask_n[1]) begin
				lane_merge[DATA_W-1:`LANE_W] = new_w[DATA_W-1:`LANE_W];
			end
		end
	endfunction

	wire [IN_W-1:0] pin_raw;
	wire [IN_W-1:0] pin_lvl;
	wire [IN_W-1:0] pin_rise;
	wire [DATA_W-1:0] s_dq;
	wire [1:0] s_mask_n;
	wire [ADDR_W-1:0] s_addr;
	wire s_rw;
	wire s_ld_n;
	wire s_delay_loop_off_n_n;
	wire k_rise;
	wire kn_rise;
	wire out_p_rise;
	wire out_n_rise;
	wire first_edge;
	wire second_edge;
	wire cmd_take;
	wire rd_cmd;
	wire wr_cmd;

	reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	reg [2:0] settle;
	reg strap_ok;
	reg [ADDR_W-1:0] rd_addr;
	reg burst_cnt;
	reg rd_fetch;
	reg [2*DATA_W-1:0] stg_word;
	reg stg_valid;
	reg stg_aged;
	reg [ADDR_W-1:0] wr_addr;
	reg wr_arm;
	reg [ADDR_W-1:0] beat_addr;
	reg beat2;
	reg cm_go;
	reg [ADDR_W-1:0] cm_addr;
	reg [DATA_W-1:0] cm_data;
	reg [1:0] cm_mask_n;
	reg [2:0] ost;

	wire f_in_valid;
	wire f_in_ready;
	wire f_out_valid;
	wire f_out_ready;
	wire [2*DATA_W-1:0] f_out_data;
	wire push;

	assign pin_raw = {dq_in, lane_write_mask_n, addr, rw_sel, load_strobe_n,
		delay_loop_off_n, c_n, c, k_n, k};

	pin_sync #(.W(IN_W)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din(pin_raw),
		.level(pin_lvl),
		.rise(pin_rise)
	);

	assign k_rise = pin_rise[0] & strap_ok;
	assign kn_rise = pin_rise[1] & strap_ok;
	assign s_delay_loop_off_n_n = pin_lvl[4];
	assign s_ld_n = pin_lvl[5];
	assign s_rw = pin_lvl[6];
	assign s_addr = pin_lvl[ADDR_W+6:7];
	assign s_mask_n = pin_lvl[ADDR_W+8:ADDR_W+7];
	assign s_dq = pin_lvl[IN_W-1:ADDR_W+9];

	// Output timing comes from the output pair, or the input pair in single-clock mode.
	assign out_p_rise = strap_ok & (single_clk_mode ? pin_rise[0] : pin_rise[2]);
	assign out_n_rise = strap_ok & (single_clk_mode ? pin_rise[1] : pin_rise[3]);
	assign first_edge = dll_mode ? out_n_rise : out_p_rise;
	assign second_edge = dll_mode ? out_p_rise : out_n_rise;

	// Control pins are looked at only on the positive input clock rise.
	assign cmd_take = k_rise & ~s_ld_n;
	assign rd_cmd = cmd_take & s_rw;
	assign wr_cmd = cmd_take & ~s_rw;

	// Straps are caught once the synchroniser has settled after reset and never again.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			settle <= 3'h0;
			strap_ok <= 1'b0;
			dll_mode <= 1'b0;
			single_clk_mode <= 1'b0;
		end else if (!strap_ok) begin
			settle <= settle + 3'h1;
			if (settle == `STRAP_SETTLE_CYC) begin
				strap_ok <= 1'b1;
				dll_mode <= s_delay_loop_off_n_n;
				single_clk_mode <= pin_lvl[2] & pin_lvl[3];
			end
		end
	end

	// Read address register and burst counter are loaded at the command edge; the
	// array is read in the next cycle so both words come from registered addresses.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_addr <= {ADDR_W{1'b0}};
			burst_cnt <= 1'b0;
			rd_fetch <= 1'b0;
		end else begin
			rd_fetch <= rd_cmd;
			if (rd_cmd) begin
				rd_addr <= s_addr;
				burst_cnt <= s_addr[0];
			end
		end
	end

	// In delay-loop mode a burst is held back until the next positive input rise.
	assign f_in_valid = stg_valid & (~dll_mode | k_rise | stg_aged);
	assign push = f_in_valid & f_in_ready;

	always @(posedge clk_sys) begin
		if (rd_fetch && !stg_valid) begin
			stg_word[DATA_W-1:0] <= mem[{rd_addr[ADDR_W-1:1], burst_cnt}];
			stg_word[2*DATA_W-1:DATA_W] <=
				mem[burst_second({rd_addr[ADDR_W-1:1], burst_cnt})];
		end
	end

	// A full FIFO holds the stage; a fetch that finds the stage still busy is
	// dropped and flagged, since the controller cannot be stalled from here.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stg_valid <= 1'b0;
			stg_aged <= 1'b0;
			read_overrun <= 1'b0;
		end else begin
			if (push) begin
				stg_valid <= 1'b0;
				stg_aged <= 1'b0;
			end else if (stg_valid && k_rise) begin
				stg_aged <= 1'b1;
			end
			if (rd_fetch) begin
				if (!stg_valid) begin
					stg_valid <= 1'b1;
					stg_aged <= 1'b0;
				end else begin
					read_overrun <= 1'b1;
				end
			end
		end
	end

	burst_fifo #(
		.WIDTH(2 * DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(stg_word),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	// Write side: address at the command edge, first beat on the next positive
	// input rise, second beat on the negative input rise that follows.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_addr <= {ADDR_W{1'b0}};
			wr_arm <= 1'b0;
			beat_addr <= {ADDR_W{1'b0}};
			beat2 <= 1'b0;
			cm_go <= 1'b0;
			cm_addr <= {ADDR_W{1'b0}};
			cm_data <= {DATA_W{1'b0}};
			cm_mask_n <= 2'h3;
		end else begin
			cm_go <= 1'b0;
			if (k_rise) begin
				wr_arm <= wr_cmd;
				if (wr_cmd) begin
					wr_addr <= s_addr;
				end
			end
			if (k_rise && wr_arm) begin
				beat_addr <= wr_addr;
				beat2 <= 1'b1;
				cm_go <= 1'b1;
				cm_addr <= wr_addr;
				cm_data <= s_dq;
				cm_mask_n <= s_mask_n;
			end else if (kn_rise && beat2) begin
				beat2 <= 1'b0;
				cm_go <= 1'b1;
				cm_addr <= burst_second(beat_addr);
				cm_data <= s_dq;
				cm_mask_n <= s_mask_n;
			end
		end
	end

	always @(posedge clk_sys) begin
		if (cm_go) begin
			mem[cm_addr] <= lane_merge(mem[cm_addr], cm_data, cm_mask_n);
		end
	end

	// Head burst leaves the FIFO only in the cycle its second word is launched,
	// so a started burst always completes.
	assign f_out_ready = (ost == OST_WORD0) & second_edge;

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ost <= OST_IDLE;
			dq_out <= {DATA_W{1'b0}};
			dq_oe <= 1'b0;
		end else begin
			case (ost)
			OST_IDLE: begin
				if (first_edge && f_out_valid) begin
					dq_out <= f_out_data[DATA_W-1:0];
					dq_oe <= 1'b1;
					ost <= OST_WORD0;
				end
			end
			OST_WORD0: begin
				if (second_edge) begin
					dq_out <= f_out_data[2*DATA_W-1:DATA_W];
					ost <= OST_WORD1;
				end
			end
			OST_WORD1: begin
				if (first_edge && f_out_valid) begin
					dq_out <= f_out_data[DATA_W-1:0];
					ost <= OST_WORD0;
				end else if (out_p_rise) begin
					dq_oe <= 1'b0;
					ost <= OST_IDLE;
				end
			end
			default: begin
				dq_oe <= 1'b0;
				ost <= OST_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== rtl/pin_sync.v
// Two-stage synchroniser with rising-edge detection for a bundle of pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter W = 8
) (
	input wire clk_sys, // system clock
	input wire rst, // asynchronous reset, active high
	input wire [W-1:0] din, // raw pin levels
	output wire [W-1:0] level, // synchronised levels
	output wire [W-1:0] rise // one-cycle pulse on each rising edge
);
	reg [W-1:0] meta;
	reg [W-1:0] sync;
	reg [W-1:0] prev;

	// The first stage feeds only the second, so every bit sees equal latency
	// and the data bits stay aligned with the clock-pin edges detected here.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta <= {W{1'b0}};
			sync <= {W{1'b0}};
			prev <= {W{1'b0}};
		end else begin
			meta <= din;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise = sync & ~prev;
endmodule
`default_nettype wire

// ===== test/ddr_burst_sram_read_port_checker.sv
// Assertions on read latency, output timing and strap capture of the read port.
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_sram_read_port_checker #(
	parameter DATA_W = 18
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // reset
	input wire logic k, // input clock
	input wire logic k_n, // input clock, negative
	input wire logic c, // output clock
	input wire logic c_n, // output clock, negative
	input wire logic load_strobe_n, // command strobe
	input wire logic rw_sel, // direction
	input wire logic delay_loop_off_n, // latency strap
	input wire logic [DATA_W-1:0] dq_out, // driven data
	input wire logic dq_oe, // pin drive
	input wire logic dll_mode, // strap result
	input wire logic single_clk_mode, // strap result
	input wire logic read_overrun // dropped burst
);
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [6:0] since_rd;
	logic [3:0] since_oclk;
	logic [3:0] since_rst;
	wire oc = single_clk_mode ? k : c;
	wire ocn = single_clk_mode ? k_n : c_n;
	// Counters saturate so that a long idle stretch never wraps into a false match.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			since_rd <= 7'h7F;
			since_oclk <= 4'hF;
			since_rst <= 4'h0;
		end else begin
			since_rd <= ($rose(k) && !load_strobe_n && rw_sel) ? 7'h0 :
				since_rd + 7'(since_rd != 7'h7F);
			since_oclk <= ($rose(oc) || $rose(ocn)) ? 4'h0 :
				since_oclk + 4'(since_oclk != 4'hF);
			since_rst <= since_rst + 4'(since_rst != 4'hF);
		end
	end
	a_reset_idle: assert property ($fell(rst) |-> !dq_oe [*8])
		else $error("pins driven just after reset");
	a_launch_clock: assert property (
		$changed(dq_out) || $changed(dq_oe) |-> since_oclk < 4'h7)
		else $error("output change away from an output clock edge");
	a_idle_float: assert property (since_rd > 7'h3C |-> !dq_oe)
		else $error("pins driven with no read pending");
	a_lat_dll: assert property (
		$rose(k) && !load_strobe_n && rw_sel && dll_mode && since_rd > 7'h3C
		|-> ##20 !dq_oe ##[1:14] dq_oe)
		else $error("wrong first word time, delay loop on");
	a_lat_plain: assert property (
		$rose(k) && !load_strobe_n && rw_sel && !dll_mode && since_rd > 7'h3C
		|-> ##12 !dq_oe ##[1:14] dq_oe)
		else $error("wrong first word time, delay loop off");
	a_no_overrun: assert property (!read_overrun)
		else $error("burst dropped");
	a_strap_take: assert property (since_rst == 4'hC |->
		dll_mode == delay_loop_off_n && single_clk_mode == (c && c_n))
		else $error("strap captured wrongly");
	a_strap_hold: assert property (
		since_rst == 4'hF |-> $stable(dll_mode) && $stable(single_clk_mode))
		else $error("strap result changed");
	a_word_hold: assert property ($rose(dq_oe) |=> $stable(dq_out) [*5])
		else $error("first word not held");
	cover property (dll_mode && $rose(dq_oe));
	cover property (!dll_mode && $rose(dq_oe));
	cover property (single_clk_mode && $fell(dq_oe));
endmodule
bind ddr_burst_sram_read_port ddr_burst_sram_read_port_checker #(.DATA_W(DATA_W)) u_checker (
	.clk_sys(clk_sys), .rst(rst), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
	.load_strobe_n(load_strobe_n), .rw_sel(rw_sel), .delay_loop_off_n(delay_loop_off_n),
	.dq_out(dq_out), .dq_oe(dq_oe), .dll_mode(dll_mode),
	.single_clk_mode(single_clk_mode), .read_overrun(read_overrun));
`default_nettype wire

// ===== test/sram_ctrl_model.sv
// Controller model: clock pairs, command pins and write data on the shared pins.
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_model #(
	parameter ADDR_W = 4,
	parameter DATA_W = 18
) (
	input wire logic clk_sys, // system clock
	input wire logic single, // tie output clocks high
	input wire logic [DATA_W-1:0] dq_out, // device data
	input wire logic dq_oe, // device drives
	output logic k, // input clock
	output wire logic k_n, // input clock, negative
	output wire logic c, // output clock
	output wire logic c_n, // output clock, negative
	output logic load_strobe_n, // command strobe
	output logic rw_sel, // direction
	output logic [ADDR_W-1:0] addr, // address
	output wire logic [DATA_W-1:0] dq_in // resolved pins
);
	logic drv = 1'b0;
	logic [DATA_W-1:0] wd = '0;
	assign k_n = ~k;
	assign c = single | k;
	assign c_n = single | k_n;
	// A released bus shows the inverse of the last beat, never a stale copy.
	assign dq_in = dq_oe ? dq_out : (drv ? wd : ~wd);
	initial begin
		k = 1'b0;
		load_strobe_n = 1'b1;
		rw_sel = 1'b0;
		addr = '0;
		#3;
		forever #80 k = ~k;
	end
	// Pins change half a cycle from the taking edge, so setup and hold are both wide.
	task automatic cmd(input logic ld_n, input logic rw, input logic [ADDR_W-1:0] a);
		@(negedge k);
		@(posedge clk_sys);
		load_strobe_n <= ld_n;
		rw_sel <= rw;
		addr <= a;
	endtask
	task automatic wdata(input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1);
		@(negedge k);
		@(posedge clk_sys);
		drv <= 1'b1;
		wd <= d0;
		@(posedge k);
		repeat (4) @(posedge clk_sys);
		wd <= d1;
		@(posedge k_n);
		repeat (4) @(posedge clk_sys);
		drv <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== test/tb_ddr_burst_sram_read_port.sv
// Self-checking bench for the burst SRAM read port in its three clocking modes.
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_burst_sram_read_port;
	localparam AW = 4;
	localparam DW = 18;
	typedef struct packed {
		logic [AW-1:0] a;
		logic [DW-1:0] d0;
		logic [DW-1:0] d1;
	} row_t;
	// Each row writes a pair, which is then read from both halves.
	row_t rows [4] = '{
		'{4'h0, 18'h3FFFF, 18'h00000},
		'{4'h3, 18'h2AAAA, 18'h15555},
		'{4'h4, 18'h00001, 18'h20000},
		'{4'hF, 18'h1E0F0, 18'h0C3A5}
	};
	// Written with lane 0 masked off, over the pair left by the first row.
	row_t mask_row = '{4'h0, 18'h00000, 18'h3FFFF};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic single = 1'b0;
	logic delay_loop_off_n = 1'b1;
	logic [1:0] lane_write_mask_n = 2'h0;
	wire k, k_n, c, c_n, load_strobe_n, rw_sel;
	wire [AW-1:0] addr;
	wire [DW-1:0] dq_in, dq_out;
	wire dq_oe, dll_mode, single_clk_mode, read_overrun;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	ddr_burst_sram_read_port #(.ADDR_W(AW)) u_ddr_burst_sram_read_port (
		.clk_sys(clk_sys), .rst(rst), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
		.load_strobe_n(load_strobe_n), .rw_sel(rw_sel), .addr(addr),
		.lane_write_mask_n(lane_write_mask_n), .delay_loop_off_n(delay_loop_off_n),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dll_mode(dll_mode),
		.single_clk_mode(single_clk_mode), .read_overrun(read_overrun));
	sram_ctrl_model #(.ADDR_W(AW), .DATA_W(DW)) u_sram_ctrl_model (
		.clk_sys(clk_sys), .single(single), .dq_out(dq_out), .dq_oe(dq_oe), .k(k),
		.k_n(k_n), .c(c), .c_n(c_n), .load_strobe_n(load_strobe_n), .rw_sel(rw_sel),
		.addr(addr), .dq_in(dq_in));
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			finish_test();
		end
	end
	task automatic finish_test;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Words are sampled well after launch, where they stand until the next one.
	task automatic chk(input logic [DW-1:0] e0, input logic [DW-1:0] e1);
		@(posedge k);
		if (dll_mode)
			@(posedge k_n);
		repeat (6) @(negedge clk_sys);
		cmp(dq_out, e0);
		if (dll_mode)
			@(posedge k);
		else
			@(posedge k_n);
		repeat (6) @(negedge clk_sys);
		cmp(dq_out, e1);
	endtask
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e0, input logic [DW-1:0] e1);
		u_sram_ctrl_model.cmd(1'b0, 1'b1, a);
		@(posedge k);
		fork
			chk(e0, e1);
		join_none
	endtask
	task automatic wr(input row_t r);
		u_sram_ctrl_model.cmd(1'b0, 1'b0, r.a);
		@(posedge k);
		fork
			u_sram_ctrl_model.wdata(r.d0, r.d1);
		join_none
	endtask
	task automatic nop;
		u_sram_ctrl_model.cmd(1'b1, 1'b0, ~addr);
		@(posedge k);
	endtask
	task automatic start(input logic dl, input logic sg);
		@(posedge clk_sys);
		rst <= 1'b1;
		delay_loop_off_n <= dl;
		single <= sg;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		cmp(DW'(dq_oe), '0);
		repeat (20) @(negedge clk_sys);
		cmp(DW'(dll_mode), DW'(dl));
		cmp(DW'(single_clk_mode), DW'(sg));
	endtask
	initial begin
		for (int m = 0; m < 3; m++) begin
			start(m != 1, m == 2);
			foreach (rows[i]) begin
				wr(rows[i]);
				nop();
			end
			nop();
			// All eight reads go back to back.
			foreach (rows[i]) begin
				rd(rows[i].a, rows[i].d0, rows[i].d1);
				rd(rows[i].a ^ 4'h1, rows[i].d1, rows[i].d0);
			end
			repeat (4) nop();
			cmp(DW'(dq_oe), '0);
			cmp(DW'(read_overrun), '0);
			$display("mode %0d done", m);
		end
		// The mask must stand across both beats, so it is restored only after
		// the second beat has been taken.
		@(posedge clk_sys);
		lane_write_mask_n <= 2'h1;
		wr(mask_row);
		repeat (2) nop();
		@(posedge clk_sys);
		lane_write_mask_n <= 2'h0;
		rd(4'h0, 18'h001FF, 18'h3FE00);
		repeat (4) nop();
		cmp(DW'(dq_oe), '0);
		$display("mask test done");
		finish_test();
	end
endmodule
`default_nettype wire
